// ### src/power_mode_controller.sv
// power mode controller: mode state machine, system clock divider,
// peripheral clock gating and the apb register slave.
// assumes ref_clk stands for the fast internal oscillator, irq_pending and
// sys_reset_req come from logic on ref_clk, and the usb, reset and slow oscillator pins are asynchronous.
`timescale 1ns/1ps

// Operation
// R1: idle halts core, peripherals run, interrupt wakes
// R2: suspend needs fast oscillator; usb activity wakes; the code tests the prior src_fast, so one write can pair suspend with slow
// R3: stop cuts power nets; any reset wakes
// R4: stop with config bit set enters shutdown
// R5: shutdown exits only on pin or power-on reset
// R6: reset clock is fast oscillator /4 /8
// R7: programmable divider of 1, 2, 4, 8
// R8: unused peripheral clocks are gated off
// R9: normal mode clocks core and all peripherals; the code clocks only the peripherals set in pclk_mask, which reset clears
// R10: wake clears request bit, returns to normal
module power_mode_controller
    import pmc_pkg::*;
#(
    parameter int NUM_PERIPH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // register bus
    input wire apb_req_s apb_req,
    output apb_rsp_s apb_rsp,
    // wake and reset sources
    input wire logic irq_pending,
    input wire logic usb_bus_level,
    input wire logic external_reset_n,
    input wire logic power_on_reset,
    input wire logic sys_reset_req,
    input wire logic slow_osc_clk,
    // clock and power controls
    output logic system_clock_tick,
    output logic core_clk_en,
    output logic [NUM_PERIPH-1:0] periph_clk_en,
    output logic power_nets_on,
    output logic pin_hold,
    output logic reg5v_on
);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        mode_e mode;
        logic idle_req;
        logic stop_req;
        logic susp_req;
        logic src_fast;
        logic prediv_en;
        logic [1:0] div_sel;
        logic deep_stop_config_bit;
        logic reg5v_en;
        logic [NUM_PERIPH-1:0] pclk_mask;
        logic usb_s1;
        logic usb_s2;
        logic usb_s3;
        logic xrst_s1;
        logic xrst_s2;
        logic por_s1;
        logic por_s2;
        logic slow_s1;
        logic slow_s2;
        logic slow_s3;
        logic [DIV_CNT_W-1:0] div_cnt;
        logic system_clock_tick;
        logic core_clk_en;
        logic [NUM_PERIPH-1:0] periph_clk_en;
        logic power_nets_on;
        logic pin_hold;
        logic reg5v_on;
        apb_rsp_s rsp;
    } state_s;

    state_s q;
    state_s d;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // address decode for the error path only; read and write paths decode in their own case statements
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == OFS_POWER_CTRL) || (a == OFS_FAST_OSC_CTRL) ||
                   (a == OFS_REGULATOR_CTRL) || (a == OFS_PERIPH_CLK) ||
                   (a == OFS_STATUS);
    endfunction : addr_hit

    // division ratio: optional fixed /4 then 1, 2, 4 or 8
    function automatic logic [DIV_CNT_W-1:0] div_period(
        input logic prediv,
        input logic [1:0] sel
    );
        logic [DIV_CNT_W-1:0] base;
        base = prediv ? PREDIV_RATIO : NO_PREDIV;
        div_period = DIV_CNT_W'(base << sel);
    endfunction : div_period

    // read data for one register word, unused bits read as zero
    function automatic logic [31:0] read_word(
        input state_s s,
        input logic [ADDR_W-1:0] a
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            OFS_POWER_CTRL: begin
                w[PWR_IDLE_BIT] = s.idle_req;
                w[PWR_STOP_BIT] = s.stop_req;
            end
            OFS_FAST_OSC_CTRL: begin
                w[OSC_SUSPEND_BIT] = s.susp_req;
                w[OSC_SRC_FAST_BIT] = s.src_fast;
                w[OSC_PREDIV_BIT] = s.prediv_en;
                w[OSC_DIV_LSB +: 2] = s.div_sel;
            end
            OFS_REGULATOR_CTRL: begin
                w[REG_DEEP_STOP_CONFIG_BIT_BIT] = s.deep_stop_config_bit;
                w[REG_5V_EN_BIT] = s.reg5v_en;
            end
            OFS_PERIPH_CLK: begin
                w[NUM_PERIPH-1:0] = s.pclk_mask;
            end
            OFS_STATUS: begin
                w[STAT_MODE_LSB +: 3] = s.mode;
                w[STAT_NETS_BIT] = s.power_nets_on;
                w[STAT_HOLD_BIT] = s.pin_hold;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        read_word = w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic usb_evt;
    logic pin_rst;
    logic any_rst;
    logic slow_tick;
    logic src_tick;
    logic running;
    logic access;
    logic [31:0] wd;
    logic pwr_wr;
    logic osc_wr;

    always_comb begin
        d = q;
        // pin synchronisers; edge detect reads only the second stage on
        d.usb_s1 = usb_bus_level;
        d.usb_s2 = q.usb_s1;
        d.usb_s3 = q.usb_s2;
        d.xrst_s1 = external_reset_n;
        d.xrst_s2 = q.xrst_s1;
        d.por_s1 = power_on_reset;
        d.por_s2 = q.por_s1;
        d.slow_s1 = slow_osc_clk;
        d.slow_s2 = q.slow_s1;
        d.slow_s3 = q.slow_s2;
        usb_evt = q.usb_s2 ^ q.usb_s3;
        pin_rst = !q.xrst_s2 || q.por_s2;
        any_rst = pin_rst || sys_reset_req;
        slow_tick = q.slow_s2 && !q.slow_s3;

        // apb: one wait state, pready high in the second access cycle
        wd = apb_req.pwdata;
        access = apb_req.psel && apb_req.penable && q.rsp.pready;
        pwr_wr = access && apb_req.pwrite &&
                 (apb_req.paddr == OFS_POWER_CTRL);
        osc_wr = access && apb_req.pwrite &&
                 (apb_req.paddr == OFS_FAST_OSC_CTRL);
        d.rsp.pready = 1'b0;
        d.rsp.pslverr = 1'b0;
        if (apb_req.psel && apb_req.penable && !q.rsp.pready) begin
            d.rsp.pready = 1'b1;
            d.rsp.pslverr = !addr_hit(apb_req.paddr);
            d.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 :
                           read_word(q, apb_req.paddr);
        end

        // register writes take effect at the completing edge
        if (access && apb_req.pwrite) begin
            case (apb_req.paddr)
                OFS_POWER_CTRL: begin
                    d.idle_req = wd[PWR_IDLE_BIT]; // R1
                    d.stop_req = wd[PWR_STOP_BIT]; // R3
                end
                OFS_FAST_OSC_CTRL: begin
                    // suspend refused unless already on the fast source
                    d.susp_req = wd[OSC_SUSPEND_BIT] && q.src_fast; // R2
                    d.src_fast = wd[OSC_SRC_FAST_BIT];
                    d.prediv_en = wd[OSC_PREDIV_BIT];
                    d.div_sel = wd[OSC_DIV_LSB +: 2]; // R7
                end
                OFS_REGULATOR_CTRL: begin
                    d.deep_stop_config_bit = wd[REG_DEEP_STOP_CONFIG_BIT_BIT]; // R4
                    d.reg5v_en = wd[REG_5V_EN_BIT];
                end
                OFS_PERIPH_CLK: begin
                    d.pclk_mask = wd[NUM_PERIPH-1:0]; // R8
                end
                default: begin
                    d.mode = q.mode;
                end
            endcase
        end

        // mode machine; stop outranks suspend, suspend outranks idle
        // a request rewritten in the wake cycle wins, so it is not lost
        case (q.mode)
            MODE_NORMAL: begin
                if (q.stop_req) begin
                    d.mode = q.deep_stop_config_bit ? MODE_SHUTDOWN : MODE_STOP; // R4
                end else if (q.susp_req) begin
                    d.mode = MODE_SUSPEND; // R2
                end else if (q.idle_req) begin
                    d.mode = MODE_IDLE; // R1
                end
            end
            MODE_IDLE: begin
                if (irq_pending) begin
                    d.mode = MODE_NORMAL; // R10
                    d.idle_req = d.idle_req && pwr_wr; // R1
                end
            end
            MODE_SUSPEND: begin
                if (usb_evt) begin
                    d.mode = MODE_NORMAL; // R10
                    d.susp_req = d.susp_req && osc_wr; // R2
                end
            end
            MODE_STOP: begin
                if (any_rst) begin
                    d.mode = MODE_NORMAL; // R10
                    d.stop_req = d.stop_req && pwr_wr; // R3
                end
            end
            MODE_SHUTDOWN: begin
                // internal reset requests cannot reach a powered-off core
                if (pin_rst) begin
                    d.mode = MODE_NORMAL; // R10
                    d.stop_req = d.stop_req && pwr_wr; // R5
                end
            end
            default: begin
                d.mode = MODE_NORMAL;
            end
        endcase

        // clock, power net and pin hold controls follow the mode being entered; reg5v_on follows reg5v_en in every mode
        running = (d.mode == MODE_NORMAL) || (d.mode == MODE_IDLE);
        d.core_clk_en = (d.mode == MODE_NORMAL); // R9
        d.periph_clk_en = d.pclk_mask & {NUM_PERIPH{running}}; // R8
        d.power_nets_on = running || (d.mode == MODE_SUSPEND); // R3
        d.pin_hold = (d.mode == MODE_STOP) ||
                     (d.mode == MODE_SHUTDOWN); // R5
        d.reg5v_on = d.reg5v_en; // R4

        // system clock divider, ticks only while clocks run
        src_tick = q.src_fast ? 1'b1 : slow_tick;
        d.system_clock_tick = 1'b0;
        if (src_tick) begin
            if (q.div_cnt >= div_period(q.prediv_en, q.div_sel) -
                             DIV_CNT_W'(1)) begin
                d.div_cnt = '0;
                d.system_clock_tick = running; // R6
            end else begin
                d.div_cnt = q.div_cnt + DIV_CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; reset brings up normal mode on fast osc /4 /8
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '0;
            q.mode <= MODE_NORMAL; // R9
            q.src_fast <= RST_SRC_FAST; // R6
            q.prediv_en <= RST_PREDIV; // R6
            q.div_sel <= RST_DIV_SEL; // R6
            q.reg5v_en <= RST_5V_EN;
            q.reg5v_on <= RST_5V_EN;
            q.xrst_s1 <= 1'b1;
            q.xrst_s2 <= 1'b1;
            q.core_clk_en <= 1'b1;
            q.power_nets_on <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign apb_rsp = q.rsp;
    assign system_clock_tick = q.system_clock_tick;
    assign core_clk_en = q.core_clk_en;
    assign periph_clk_en = q.periph_clk_en;
    assign power_nets_on = q.power_nets_on;
    assign pin_hold = q.pin_hold;
    assign reg5v_on = q.reg5v_on;

endmodule : power_mode_controller

// ### src/pmc_pkg.sv
// power mode controller: register map, field positions, reset values,
// mode enumeration and the apb carrier structs.
// assumes a 32-bit apb master with byte addresses on paddr.
package pmc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_POWER_CTRL = 12'h000;
    localparam logic [11:0] OFS_FAST_OSC_CTRL = 12'h004;
    localparam logic [11:0] OFS_REGULATOR_CTRL = 12'h008;
    localparam logic [11:0] OFS_PERIPH_CLK = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam int OSC_SUSPEND_BIT = 0;
    localparam int OSC_SRC_FAST_BIT = 1;
    localparam int OSC_PREDIV_BIT = 2;
    localparam int OSC_DIV_LSB = 4;
    localparam int REG_DEEP_STOP_CONFIG_BIT_BIT = 0;
    localparam int REG_5V_EN_BIT = 1;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_NETS_BIT = 4;
    localparam int STAT_HOLD_BIT = 5;

    ////////////////////////////////////////////////////////////////////////
    // reset values and divider figures
    localparam logic RST_SRC_FAST = 1'b1;
    localparam logic RST_PREDIV = 1'b1;
    localparam logic [1:0] RST_DIV_SEL = 2'h3;
    localparam logic RST_5V_EN = 1'b1;
    localparam logic [5:0] PREDIV_RATIO = 6'h04;
    localparam logic [5:0] NO_PREDIV = 6'h01;
    localparam int DIV_CNT_W = 6;

    ////////////////////////////////////////////////////////////////////////
    // operating modes
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_IDLE,
        MODE_SUSPEND,
        MODE_STOP,
        MODE_SHUTDOWN
    } mode_e;

    ////////////////////////////////////////////////////////////////////////
    // apb carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

endpackage : pmc_pkg

// ### sim/pmc_properties.sv
// port checker for the power mode controller
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module pmc_properties
    import pmc_pkg::*;
#(
    parameter int NUM_PERIPH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // register bus
    input wire apb_req_s apb_req,
    input wire apb_rsp_s apb_rsp,
    // wake sources
    input wire logic irq_pending,
    input wire logic usb_bus_level,
    input wire logic external_reset_n,
    input wire logic power_on_reset,
    input wire logic sys_reset_req,
    input wire logic slow_osc_clk,
    // clock and power controls
    input wire logic system_clock_tick,
    input wire logic core_clk_en,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en,
    input wire logic power_nets_on,
    input wire logic pin_hold,
    input wire logic reg5v_on
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // steps of a bus transfer and a quiet reset picture
    sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
    sequence s_access; apb_req.psel && apb_req.penable; endsequence
    // four cycles, so the pin synchronisers are flushed too
    sequence s_quiet;
        (external_reset_n && !power_on_reset && !sys_reset_req)[*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    property p_one_wait;
        s_setup ##1 s_access |-> !apb_rsp.pready ##1 apb_rsp.pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bad wait");
    property p_ready_pulse;
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready");
    property p_err_qual;
        apb_rsp.pslverr |-> apb_rsp.pready;
    endproperty
    a_err_qual: assert property (p_err_qual) else $error("pslverr");
    property p_idle_wake;
        !core_clk_en && power_nets_on && (|periph_clk_en) && irq_pending
            |=> core_clk_en;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle");
    property p_hold_off;
        pin_hold |-> !power_nets_on && !core_clk_en;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("nets");
    property p_core_on;
        core_clk_en |-> power_nets_on && !pin_hold;
    endproperty
    a_core_on: assert property (p_core_on) else $error("normal");
    property p_hold_keep;
        s_quiet ##0 pin_hold |=> pin_hold;
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("exit");
    property p_reset_clk;
        $fell(reset) |-> ##[0:32] system_clock_tick ##32 system_clock_tick;
    endproperty
    a_reset_clk: assert property (p_reset_clk) else $error("div");
    property p_5v_keep;
        pin_hold ##1 pin_hold |-> $stable(reg5v_on);
    endproperty
    a_5v_keep: assert property (p_5v_keep) else $error("5v");
endmodule : pmc_properties

bind power_mode_controller pmc_properties #(.NUM_PERIPH(NUM_PERIPH)) u_p (
    .ref_clk(ref_clk), .reset(reset), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .irq_pending(irq_pending),
    .usb_bus_level(usb_bus_level), .external_reset_n(external_reset_n),
    .power_on_reset(power_on_reset), .sys_reset_req(sys_reset_req),
    .slow_osc_clk(slow_osc_clk), .system_clock_tick(system_clock_tick),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .power_nets_on(power_nets_on), .pin_hold(pin_hold),
    .reg5v_on(reg5v_on));

// ### sim/core_model.sv
// apb master standing for the processor core
// assumes requests change only just after a rising edge
`timescale 1ns/1ps
module core_model
    import pmc_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register bus
    output apb_req_s apb_req,
    input wire apb_rsp_s apb_rsp
);
    initial apb_req = '0;
    // one transfer; waits on pready, so no wait-state count is assumed
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge ref_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        @(posedge ref_clk);
        while (apb_rsp.pready !== 1'b1) @(posedge ref_clk);
        q = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        // released lines show the inverse so stale values never pass
        apb_req <= '{1'b0, 1'b0, ~wr, ~a, ~d};
    endtask : xfer
endmodule : core_model

// ### sim/tb.sv
// self-checking bench for the power mode controller
// assumes the core model as apb master and a 100 MHz clock
`timescale 1ns/1ps
module tb import pmc_pkg::*;;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic irq_pending = 1'b0;
    logic usb_bus_level = 1'b0;
    logic external_reset_n = 1'b1;
    logic sys_reset_req = 1'b0;
    logic power_on_reset = 1'b0;
    apb_req_s apb_req;
    apb_rsp_s apb_rsp;
    logic tick, core, nets, hold, v5;
    logic [7:0] pclk;
    logic [31:0] q;
    logic err;
    int errors = 0;
    int n_tests = 0;
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    // slow oscillator stays idle in this bench
    power_mode_controller dut (.ref_clk(ref_clk), .reset(reset),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .irq_pending(irq_pending),
        .usb_bus_level(usb_bus_level), .external_reset_n(external_reset_n),
        .power_on_reset(power_on_reset), .sys_reset_req(sys_reset_req),
        .slow_osc_clk(1'b0), .system_clock_tick(tick), .core_clk_en(core),
        .periph_clk_en(pclk), .power_nets_on(nets), .pin_hold(hold),
        .reg5v_on(v5));
    core_model core_m (.ref_clk(ref_clk), .apb_req(apb_req),
        .apb_rsp(apb_rsp));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        core_m.xfer(1'b1, a, d, q, err);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        core_m.xfer(1'b0, a, 32'h0, q, err);
    endtask : rd
    // settle just past the edge so registered outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic pulse_sys;
        @(posedge ref_clk) sys_reset_req <= 1'b1;
        @(posedge ref_clk) sys_reset_req <= 1'b0;
    endtask : pulse_sys
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(OFS_FAST_OSC_CTRL);
        chk(q, 32'h36);
        rd(12'hFFC);
        chk(q, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(OFS_STATUS, 32'h3);
        rd(OFS_STATUS);
        chk(q, 32'h10);
        chk({core, nets, hold, v5}, 4'hD);
    endtask : t_regs
    task automatic t_idle;
        wr(OFS_PERIPH_CLK, 32'h5A);
        wr(OFS_POWER_CTRL, 32'h1);
        step(2);
        chk({core, nets, pclk}, 10'h15A);
        @(posedge ref_clk) irq_pending <= 1'b1;
        step(1);
        chk(core, 1'b1);
        @(posedge ref_clk) irq_pending <= 1'b0;
        rd(OFS_POWER_CTRL);
        chk(q, 32'h0);
    endtask : t_idle
    task automatic t_stop;
        wr(OFS_POWER_CTRL, 32'h2);
        step(2);
        chk({core, nets, hold}, 3'h1);
        pulse_sys();
        step(1);
        chk({core, nets, hold}, 3'h6);
    endtask : t_stop
    task automatic t_shut;
        wr(OFS_REGULATOR_CTRL, 32'h3);
        wr(OFS_POWER_CTRL, 32'h2);
        pulse_sys();
        step(3);
        chk({nets, hold, v5}, 3'h3);
        @(posedge ref_clk) external_reset_n <= 1'b0;
        @(posedge ref_clk) external_reset_n <= 1'b1;
        step(4);
        chk({core, hold}, 2'h2);
        // second entry, left by a power-on reset this time
        wr(OFS_POWER_CTRL, 32'h2);
        step(2);
        chk({nets, hold}, 2'h1);
        @(posedge ref_clk) power_on_reset <= 1'b1;
        @(posedge ref_clk) power_on_reset <= 1'b0;
        step(4);
        chk({core, hold}, 2'h2);
        wr(OFS_REGULATOR_CTRL, 32'h2);
    endtask : t_shut
    task automatic t_div;
        int n;
        for (int s = 0; s < 4; s++) begin
            wr(OFS_FAST_OSC_CTRL, 32'h2 | (s << 4));
            repeat (2) do step(1); while (!tick);
            n = 0;
            do begin
                step(1);
                n++;
            end while (!tick);
            chk(n, 1 << s);
        end
    endtask : t_div
    task automatic t_susp;
        // suspend off the fast source must be refused
        wr(OFS_FAST_OSC_CTRL, 32'h34);
        wr(OFS_FAST_OSC_CTRL, 32'h35);
        rd(OFS_FAST_OSC_CTRL);
        chk(q, 32'h34);
        wr(OFS_FAST_OSC_CTRL, 32'h36);
        wr(OFS_FAST_OSC_CTRL, 32'h37);
        step(2);
        chk({core, nets, pclk}, 10'h100);
        @(posedge ref_clk) usb_bus_level <= 1'b1;
        step(5);
        chk(core, 1'b1);
        rd(OFS_FAST_OSC_CTRL);
        chk(q, 32'h36);
    endtask : t_susp
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // the default divider runs two periods before any mode change
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (64) @(posedge ref_clk);
        t_regs();
        t_idle();
        t_stop();
        t_shut();
        t_div();
        t_susp();
        conclude();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        conclude();
    end
endmodule : tb
